// ### pixel_input_checker_properties.sv
// Checker of capture, framing and link clock relations at the pixel port
module pixel_input_checker
    import pixel_input_pkg::*;
(
    // Clock and reset
    input wire logic                                   clk_in,
    input wire logic                                   rst_n_in,
    // Video inputs
    input wire logic                                   vid_rst_in,
    input wire logic                                   vsync_in,
    input wire logic                                   odd_field_in,
    input wire logic                                   data_valid_in,
    // Capture outputs
    input wire logic                                   pix_valid_out,
    input wire logic [4*pixel_input_pkg::PIXEL_W-1:0] pix_data_out,
    input wire logic [3:0]                             pix_lane_en_out,
    input wire logic                                   pix_odd_out,
    input wire logic                                   frame_start_out,
    input wire logic                                   link_clk_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Five cycles back lies inside the stable half of the video period
    property p_cap_enable; pix_valid_out |-> $past(data_valid_in, 5); endproperty
    a_cap_enable: assert property (p_cap_enable) else $error("capture without valid");
    property p_cap_once; pix_valid_out |=> !pix_valid_out; endproperty
    a_cap_once: assert property (p_cap_once) else $error("capture longer than a pulse");
    property p_lane_a; pix_lane_en_out[0]; endproperty
    a_lane_a: assert property (p_lane_a) else $error("first lane disabled");
    property p_lane_b; pix_valid_out && !pix_lane_en_out[1] |-> pix_data_out[95:48] == '0;
    endproperty
    a_lane_b: assert property (p_lane_b) else $error("disabled lane b carries data");
    property p_lane_c; pix_valid_out && !pix_lane_en_out[2] |-> pix_data_out[143:96] == '0;
    endproperty
    a_lane_c: assert property (p_lane_c) else $error("disabled lane c carries data");
    property p_frame; $fell(vsync_in) |-> ##[1:40] frame_start_out; endproperty
    a_frame: assert property (p_frame) else $error("no frame start after sync");
    property p_frame_low; frame_start_out |-> !$past(vsync_in) ##1 !frame_start_out; endproperty
    a_frame_low: assert property (p_frame_low) else $error("frame start misplaced");
    property p_link; $rose(link_clk_out) |=> link_clk_out ##1 !link_clk_out [*2] ##1 link_clk_out;
    endproperty
    a_link: assert property (p_link) else $error("link clock not a quarter rate");
    property p_vid_rst; vid_rst_in [*8] |-> !pix_valid_out; endproperty
    a_vid_rst: assert property (p_vid_rst) else $error("capture during video reset");
    property p_odd; pix_valid_out |-> pix_odd_out == $past(odd_field_in, 5); endproperty
    a_odd: assert property (p_odd) else $error("field flag wrong");

    c_all_lanes: cover property (pix_valid_out && pix_lane_en_out == 4'hf);
    c_frame: cover property (frame_start_out);
    c_reset_line: cover property (vid_rst_in && data_valid_in);
endmodule : pixel_input_checker

bind pixel_input_port pixel_input_checker pixel_input_checker_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .vid_rst_in(vid_rst_in), .vsync_in(vsync_in),
    .odd_field_in(odd_field_in), .data_valid_in(data_valid_in), .pix_valid_out(pix_valid_out),
    .pix_data_out(pix_data_out), .pix_lane_en_out(pix_lane_en_out),
    .pix_odd_out(pix_odd_out), .frame_start_out(frame_start_out), .link_clk_out(link_clk_out)
);

// ### pixel_input_pkg.sv
// Package of constants for the source video pixel input port
package pixel_input_pkg;
    localparam int PIXEL_W = 48;
    localparam int ADDR_W  = 6;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 6'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 6'h04;
    localparam logic [ADDR_W-1:0] FRAME_OFFSET  = 6'h08;
    localparam logic [ADDR_W-1:0] VBP_OFFSET    = 6'h0c;
    localparam logic [ADDR_W-1:0] VFP_OFFSET    = 6'h10;
    localparam logic [ADDR_W-1:0] HPORCH_OFFSET = 6'h14;
    // Control field positions
    localparam int CTRL_WIDTH_LSB  = 0;
    localparam int CTRL_LANES_LSB  = 2;
    localparam int CTRL_VALID_LSB  = 4;
    localparam int CTRL_FORMAT_LSB = 8;
    localparam int CTRL_BPC_LSB    = 12;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Pixels per clock and format codes
    typedef enum logic [1:0] {
        WIDTH_ONE  = 2'h0,
        WIDTH_TWO  = 2'h1,
        WIDTH_FOUR = 2'h2
    } ppc_t;
    typedef enum logic [1:0] {
        FMT_RGB          = 2'h0,
        FMT_YCC444       = 2'h1,
        FMT_YCC422       = 2'h2,
        luma_only_format = 2'h3
    } format_t;
endpackage : pixel_input_pkg

// ### pixel_input_port.sv
// Source video pixel input port: framing, lane qualification, timing measurement
module pixel_input_port
#(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_n_in,
    // Video input pins (video clock domain, sampled)
    input  wire logic                         vid_clk_in,
    input  wire logic                         vid_rst_in,
    input  wire logic                         vsync_in,
    input  wire logic                         hsync_in,
    input  wire logic                         odd_field_in,
    input  wire logic                         data_valid_in,
    input  wire logic [pixel_input_pkg::PIXEL_W-1:0] pixel_lane_a_in,
    input  wire logic [pixel_input_pkg::PIXEL_W-1:0] pixel_lane_b_in,
    input  wire logic [pixel_input_pkg::PIXEL_W-1:0] pixel_lane_c_in,
    input  wire logic [pixel_input_pkg::PIXEL_W-1:0] pixel_lane_d_in,
    // Captured pixel stream
    output logic                              pix_valid_out,
    output logic [4*pixel_input_pkg::PIXEL_W-1:0] pix_data_out,
    output logic [3:0]                        pix_lane_en_out,
    output logic                              pix_odd_out,
    output logic                              frame_start_out,
    output logic                              link_clk_out,
    // AXI4-Lite slave
    input  wire logic [pixel_input_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [pixel_input_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready
);
    import pixel_input_pkg::*;

    // Two-flop synchronisers; stage one is read only by stage two
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    logic [5:0] sync3_reg;
    logic [4*PIXEL_W-1:0] lanes1_reg;
    logic [4*PIXEL_W-1:0] lanes2_reg;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_reg  <= 6'h00;
            sync2_reg  <= 6'h00;
            sync3_reg  <= 6'h00;
            lanes1_reg <= '0;
            lanes2_reg <= '0;
        end else begin
            sync1_reg  <= {vid_clk_in, vid_rst_in, vsync_in, hsync_in, odd_field_in,
                           data_valid_in};
            sync2_reg  <= sync1_reg;
            sync3_reg  <= sync2_reg;
            lanes1_reg <= {pixel_lane_d_in, pixel_lane_c_in, pixel_lane_b_in,
                           pixel_lane_a_in};
            lanes2_reg <= lanes1_reg;
        end
    end

    // Pins are sampled at the system clock; inputs must be held a full video
    // period, so video clock is limited well below clk_in/2 in practice
    wire vclk_rise  = sync2_reg[5] & ~sync3_reg[5];
    wire vrst       = sync2_reg[4];
    wire vs         = sync2_reg[3];
    wire hs         = sync2_reg[2];
    wire odd        = sync2_reg[1];
    wire de         = sync2_reg[0];
    // Control register fields
    logic [31:0] ctrl_reg;
    wire  [1:0]  ppc       = ctrl_reg[CTRL_WIDTH_LSB +: 2];
    wire  [1:0]  lanes     = ctrl_reg[CTRL_LANES_LSB +: 2];
    wire  [3:0]  lane_ok   = ctrl_reg[CTRL_VALID_LSB +: 4];
    wire  [1:0]  fmt       = ctrl_reg[CTRL_FORMAT_LSB +: 2];
    wire  [4:0]  bpc       = ctrl_reg[CTRL_BPC_LSB +: 5];

    // Lane enables from width, link lanes and valid marks
    wire en_b = lane_ok[1] & (lanes != 2'h0) & (ppc != WIDTH_ONE);
    wire en_c = lane_ok[2] & (lanes == 2'h2) & (ppc == WIDTH_FOUR);
    wire en_d = lane_ok[3] & (lanes == 2'h2) & (ppc == WIDTH_FOUR);
    wire [3:0] lane_en = {en_d, en_c, en_b, 1'b1};
    // Mask below the component depth; every lane stays 48 bits wide
    wire [4:0]  depth = (bpc > 5'h10) ? 5'h10 : bpc;
    wire [15:0] comp_mask = 16'hffff << (5'h10 - depth);
    wire [PIXEL_W-1:0] fmt_mask =
        (fmt == luma_only_format) ? {comp_mask, 32'h0} :
        (fmt == FMT_YCC422)       ? {comp_mask, comp_mask, 16'h0} :
                                    {comp_mask, comp_mask, comp_mask};
    // Frame and line tracking
    logic              vs_d_reg;
    logic              hs_d_reg;
    logic              de_d_reg;
    logic              in_line_reg;
    logic              seen_active_reg;
    logic [CNT_W-1:0]  vbp_cnt_reg;
    logic [CNT_W-1:0]  vfp_cnt_reg;
    logic [CNT_W-1:0]  vbp_reg;
    logic [CNT_W-1:0]  vfp_reg;
    logic [CNT_W-1:0]  hcnt_reg;
    logic [CNT_W-1:0]  hbp_reg;
    logic [CNT_W-1:0]  hfp_reg;
    logic [CNT_W-1:0]  line_end_reg;
    logic              line_done_reg;
    logic [CNT_W-1:0]  frame_cnt_reg;
    logic              line_err_reg;
    wire vs_fall  = vclk_rise & vs_d_reg & ~vs;
    wire vs_rise  = vclk_rise & ~vs_d_reg & vs;
    wire hs_rise  = vclk_rise & ~hs_d_reg & hs;
    wire de_rise  = vclk_rise & ~de_d_reg & de;
    wire de_fall  = vclk_rise & de_d_reg & ~de;
    wire capture  = vclk_rise & de & ~vrst;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            vs_d_reg        <= 1'b0;
            hs_d_reg        <= 1'b0;
            de_d_reg        <= 1'b0;
            in_line_reg     <= 1'b0;
            seen_active_reg <= 1'b0;
            vbp_cnt_reg     <= '0;
            vfp_cnt_reg     <= '0;
            vbp_reg         <= '0;
            vfp_reg         <= '0;
            hcnt_reg        <= '0;
            hbp_reg         <= '0;
            hfp_reg         <= '0;
            line_end_reg    <= '0;
            line_done_reg   <= 1'b0;
            frame_cnt_reg   <= '0;
            line_err_reg    <= 1'b0;
        end else if (vrst) begin
            vs_d_reg        <= 1'b0;
            hs_d_reg        <= 1'b0;
            de_d_reg        <= 1'b0;
            in_line_reg     <= 1'b0;
            seen_active_reg <= 1'b0;
            vbp_cnt_reg     <= '0;
            vfp_cnt_reg     <= '0;
            hcnt_reg        <= '0;
            line_done_reg   <= 1'b0;
        end else begin
            if (vclk_rise) begin
                vs_d_reg <= vs;
                hs_d_reg <= hs;
                de_d_reg <= de;
                hcnt_reg <= hs ? '0 : hcnt_reg + 1'b1;
            end
            if (vs_fall) begin
                in_line_reg     <= 1'b0;
                seen_active_reg <= 1'b0;
                vbp_cnt_reg     <= '0;
                frame_cnt_reg   <= frame_cnt_reg + 1'b1;
            end else begin
                if (hs_rise && !seen_active_reg) begin
                    vbp_cnt_reg <= vbp_cnt_reg + 1'b1;
                end
                if (hs_rise && seen_active_reg) begin
                    vfp_cnt_reg <= vfp_cnt_reg + 1'b1;
                end
                if (de_rise) begin
                    in_line_reg <= 1'b1;
                    hbp_reg     <= hcnt_reg;
                    vfp_cnt_reg <= '0;
                    if (!seen_active_reg) begin
                        vbp_reg <= vbp_cnt_reg;
                    end
                    seen_active_reg <= 1'b1;
                end
                if (de_fall) begin
                    in_line_reg   <= 1'b0;
                    line_end_reg  <= hcnt_reg;
                    line_done_reg <= 1'b1;
                end
                if (hs_rise && line_done_reg) begin
                    hfp_reg       <= hcnt_reg - line_end_reg;
                    line_done_reg <= 1'b0;
                end
                if (hs_rise && in_line_reg) begin
                    line_err_reg <= 1'b1;
                end
            end
            if (vs_rise) begin
                vfp_reg <= vfp_cnt_reg;
            end
        end
    end
    // Captured stream, registered straight to the outputs
    integer i;
    logic [4*PIXEL_W-1:0] masked;
    always_comb begin
        masked = '0;
        for (i = 0; i < 4; i = i + 1) begin
            masked[i*PIXEL_W +: PIXEL_W] = lane_en[i] ?
                (lanes2_reg[i*PIXEL_W +: PIXEL_W] & fmt_mask) : '0;
        end
    end
    logic [1:0] lclk_div_reg;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pix_valid_out   <= 1'b0;
            pix_data_out    <= '0;
            pix_lane_en_out <= 4'h1;
            pix_odd_out     <= 1'b0;
            frame_start_out <= 1'b0;
            lclk_div_reg    <= 2'h0;
            link_clk_out    <= 1'b0;
        end else begin
            pix_valid_out   <= capture;
            if (capture) begin
                pix_data_out <= masked;
            end
            pix_lane_en_out <= lane_en;
            pix_odd_out     <= odd;
            frame_start_out <= vs_fall & ~vrst;
            lclk_div_reg    <= lclk_div_reg + 2'h1;
            link_clk_out    <= lclk_div_reg[1];
        end
    end

    // AXI4-Lite slave: one write and one read at a time
    logic [ADDR_W-1:0] awaddr_reg;
    logic              aw_held_reg;
    logic [31:0]       wdata_reg;
    logic [3:0]        wstrb_reg;
    logic              w_held_reg;
    wire do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire wr_ctrl  = do_write & (awaddr_reg == CTRL_OFFSET);
    wire wr_stat  = do_write & (awaddr_reg == STATUS_OFFSET);
    wire wr_hit   = wr_ctrl | wr_stat;
    logic [31:0] ctrl_merge;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            ctrl_merge[b*8 +: 8] = wstrb_reg[b] ? wdata_reg[b*8 +: 8] : ctrl_reg[b*8 +: 8];
        end
    end
    wire [31:0] status_word = {27'h0, line_err_reg, seen_active_reg, in_line_reg, odd, vs};
    wire [ADDR_W-1:0] ra = s_axi_araddr;
    wire ra_hit = (ra == CTRL_OFFSET) | (ra == STATUS_OFFSET) | (ra == FRAME_OFFSET) |
                  (ra == VBP_OFFSET) | (ra == VFP_OFFSET) | (ra == HPORCH_OFFSET);
    wire [31:0] rd_word =
        (ra == CTRL_OFFSET)   ? ctrl_reg :
        (ra == STATUS_OFFSET) ? status_word :
        (ra == FRAME_OFFSET)  ? {{(32-CNT_W){1'b0}}, frame_cnt_reg} :
        (ra == VBP_OFFSET)    ? {{(32-CNT_W){1'b0}}, vbp_reg} :
        (ra == VFP_OFFSET)    ? {{(32-CNT_W){1'b0}}, vfp_reg} :
        (ra == HPORCH_OFFSET) ? {hfp_reg, hbp_reg} : 32'h0;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_reg      <= CTRL_RESET;
            awaddr_reg    <= '0;
            aw_held_reg   <= 1'b0;
            wdata_reg     <= 32'h0;
            wstrb_reg     <= 4'h0;
            w_held_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_reg    <= s_axi_awaddr;
                aw_held_reg   <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
                w_held_reg   <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                if (wr_ctrl) begin
                    ctrl_reg <= ctrl_merge;
                end
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held_reg   <= 1'b0;
                w_held_reg    <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= ra_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule : pixel_input_port

// ### tb.sv
// Testbench for the pixel input port: registers, lane capture, framing, video reset
module tb;
    import pixel_input_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] cfg_ctrl [5] = '{32'h0000_80f0, 32'h0000_61f5, 32'h0000_a2fa,
                                             32'h0001_033a, 32'h0001_00f6};
    localparam logic [3:0] cfg_en [5] = '{4'h1, 4'h3, 4'hf, 4'h3, 4'h3};
    localparam logic [47:0] cfg_msk [5] = '{48'hff00_ff00_ff00, 48'hfc00_fc00_fc00,
        48'hffc0_ffc0_0000, 48'hffff_0000_0000, 48'hffff_ffff_ffff};
    localparam logic [191:0] pat = {48'h3c5a_a5c3_0ff1, 48'hf0e1_d2c3_b4a5,
                                    48'h9687_7869_5a4b, 48'h0f1e_2d3c_4b5a};
    logic clk_in = 1'h0, rst_n_in = 1'h0, vid_rst_in = 1'h0, push = 1'h1, cur_odd = 1'h0;
    logic vid_clk, vsync, hsync, odd, valid, pix_valid_out, pix_odd_out, frame_start_out;
    logic link_clk_out, awready, wready, bvalid, arready, rvalid;
    logic [191:0] lanes, pix_data_out;
    logic [191:0] exp_q [$];
    logic [3:0] pix_lane_en_out, exp_en = 4'h1;
    logic [47:0] msk = 48'h0;
    logic [5:0] awaddr = 6'h0, araddr = 6'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb = 4'hf;
    int fails = 0, n_compared = 0;

    always #4 clk_in = ~clk_in;

    video_source video_source_i (.vid_clk_out(vid_clk), .vsync_out(vsync), .hsync_out(hsync),
        .odd_out(odd), .valid_out(valid), .lanes_out(lanes));
    pixel_input_port pixel_input_port_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .vid_clk_in(vid_clk), .vid_rst_in(vid_rst_in), .vsync_in(vsync), .hsync_in(hsync),
        .odd_field_in(odd), .data_valid_in(valid), .pixel_lane_a_in(lanes[47:0]),
        .pixel_lane_b_in(lanes[95:48]), .pixel_lane_c_in(lanes[143:96]),
        .pixel_lane_d_in(lanes[191:144]), .pix_valid_out(pix_valid_out),
        .pix_data_out(pix_data_out), .pix_lane_en_out(pix_lane_en_out),
        .pix_odd_out(pix_odd_out), .frame_start_out(frame_start_out),
        .link_clk_out(link_clk_out), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    task automatic chk(input string what, input logic [191:0] got, input logic [191:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        fork
            begin
                do @(negedge clk_in); while (awready !== 1'h1);
                @(posedge clk_in);
                awvalid <= 1'h0;
            end
            begin
                do @(negedge clk_in); while (wready !== 1'h1);
                @(posedge clk_in);
                wvalid <= 1'h0;
            end
        join
        do @(negedge clk_in); while (bvalid !== 1'h1);
        chk("write response", 192'(bresp), 192'(er));
        @(posedge clk_in);
        bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(negedge clk_in); while (arready !== 1'h1);
        @(posedge clk_in);
        arvalid <= 1'h0;
        do @(negedge clk_in); while (rvalid !== 1'h1);
        chk("read data", 192'(rdata), 192'(ed));
        chk("read response", 192'(rresp), 192'(er));
        @(posedge clk_in);
        rready <= 1'h0;
    endtask : rd

    // One video period; expected capture is masked per format and zero on disabled lanes
    task automatic put(input logic v, input logic hs, input logic vs, input int k);
        logic [191:0] px, e;
        px = (pat << k) | (pat >> (192 - k));
        for (int i = 0; i < 4; i++)
            e[i*48 +: 48] = exp_en[i] ? px[i*48 +: 48] & msk : 48'h0;
        if (v && push)
            exp_q.push_back(e);
        video_source_i.tick(v, hs, vs, cur_odd, px);
    endtask : put

    task automatic scan(input int n);
        put(1'h0, 1'h1, 1'h0, 0);
        repeat (3) put(1'h0, 1'h0, 1'h0, 0);
        for (int k = 1; k <= n; k++)
            put(1'h1, 1'h0, 1'h0, k);
        put(1'h0, 1'h0, 1'h0, 0);
    endtask : scan

    task automatic frame();
        repeat (2) put(1'h0, 1'h0, 1'h1, 0);
        repeat (2) scan(0);
    endtask : frame

    always @(negedge clk_in) begin
        if (pix_valid_out === 1'h1) begin
            chk("lane enables", 192'(pix_lane_en_out), 192'(exp_en));
            chk("field", 192'(pix_odd_out), 192'(cur_odd));
            chk("pixel data", pix_data_out, exp_q.size() ? exp_q.pop_front() : 'x);
        end
    end

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #200us;
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'h1;
        rd(CTRL_OFFSET, CTRL_RESET, RESP_OKAY);
        rd(6'h18, 32'h0, RESP_SLVERR);
        wr(STATUS_OFFSET, 32'hffff_ffff, RESP_OKAY);
        for (int i = 0; i < 5; i++) begin
            wr(CTRL_OFFSET, cfg_ctrl[i], RESP_OKAY);
            rd(CTRL_OFFSET, cfg_ctrl[i], RESP_OKAY);
            exp_en = cfg_en[i];
            msk = cfg_msk[i];
            cur_odd = i[0];
            frame();
            scan(3);
            scan(4);
            scan(0);
        end
        rd(HPORCH_OFFSET, 32'h0001_0003, RESP_OKAY);
        rd(FRAME_OFFSET, 32'h5, RESP_OKAY);
        rd(VBP_OFFSET, 32'h2, RESP_OKAY);
        rd(VFP_OFFSET, 32'h1, RESP_OKAY);
        rd(STATUS_OFFSET, 32'h8, RESP_OKAY);
        // Low byte only: lane valid marks drop, so lane b must fall silent
        wstrb <= 4'h1;
        wr(CTRL_OFFSET, 32'hffff_ff05, RESP_OKAY);
        rd(CTRL_OFFSET, 32'h0001_0005, RESP_OKAY);
        exp_en = 4'h1;
        // A line sent wholly under video reset must leave no capture behind
        push = 1'h0;
        @(posedge clk_in);
        vid_rst_in <= 1'h1;
        scan(3);
        @(posedge clk_in);
        vid_rst_in <= 1'h0;
        push = 1'h1;
        frame();
        scan(2);
        repeat (2) put(1'h0, 1'h0, 1'h0, 0);
        chk("pending captures", 192'(exp_q.size()), 192'h0);
        report_and_stop();
    end
endmodule : tb

// ### video_source.sv
// Behavioural user video source: free-running video clock, syncs and pixel lanes
module video_source (
    // Video pins
    output logic         vid_clk_out,
    output logic         vsync_out,
    output logic         hsync_out,
    output logic         odd_out,
    output logic         valid_out,
    output logic [191:0] lanes_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {vid_clk_out, vsync_out, hsync_out, odd_out, valid_out} = 5'h0;
        lanes_out = '0;
    end
    always #62.5 vid_clk_out = ~vid_clk_out;
    // Pins move mid-period so every rising edge sees settled levels
    task automatic tick(input logic v, input logic hs, input logic vs, input logic od,
                        input logic [191:0] px);
        @(negedge vid_clk_out);
        hsync_out <= hs;
        vsync_out <= vs;
        odd_out <= od;
        valid_out <= v;
        lanes_out <= v ? px : ~lanes_out;
    endtask : tick
endmodule : video_source
